// File: spimss_pkg.sv
/*
 * spimss_pkg: shared widths, reset values, counts and the state type of the
 * master/slave serial controller.
 * assumes: imported whole by every design module of the controller.
 */
package spimss_pkg;

   localparam int           SPIMSS_DW        = 8;       // character width
   localparam int           SPIMSS_NCS       = 4;       // chip selects
   localparam int           SPIMSS_DIVW      = 8;       // divisor width per chip select
   localparam int           SPIMSS_CSW       = 2;       // chip select index width
   localparam int           SPIMSS_CNTW      = 5;       // clock edge counter width
   localparam int           SPIMSS_BITW      = 3;       // slave bit counter width

   localparam logic [4:0]   SPIMSS_EDGE_LAST = 5'h0f;   // 16 edges per character
   localparam logic [4:0]   SPIMSS_LEAD_LAST = 5'h01;   // two edges of the stray pulse
   localparam logic [2:0]   SPIMSS_BIT_LAST  = 3'h7;
   localparam logic [7:0]   SPIMSS_DIV_ONE   = 8'h01;
   localparam logic [7:0]   SPIMSS_DATA_RST  = 8'h00;
   localparam logic [3:0]   SPIMSS_CS_IDLE   = 4'hf;    // all selects high
   localparam logic [1:0]   SPIMSS_CS_ZERO   = 2'h0;
   localparam logic [2:0]   SPIMSS_SYNC_RST  = 3'h4;    // {select, miso, toggle}

   typedef enum logic [1:0] {
      SPIMSS_IDLE,
      SPIMSS_LEAD,
      SPIMSS_SHIFT,
      SPIMSS_DONE
   } spimss_state_t;

endpackage

// File: spimss_sync.sv
/*
 * spimss_sync: two-flop synchroniser for a group of independent levels.
 * assumes: each bit is a level or a toggle; no bit is a multi-bit word.
 */
`timescale 1ns/1ps
module spimss_sync import spimss_pkg::*; #(
   parameter int           W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // first stage is read only by the second stage
   always_comb begin
      meta_next = rst_b_i ? d_i : RST_VAL;
      q_next    = rst_b_i ? meta_reg : RST_VAL;
   end

   always_ff @(posedge clk_i) begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
   end

   assign q_o = q_reg;

endmodule // spimss_sync

// File: spimss_slave_link.sv
/*
 * spimss_slave_link: slave-side shifter clocked by the peer's serial clock.
 * assumes: peer samples on rising clock edges; the select line high ends a
 * frame and clears the bit count; tx_word_i is held still while selected.
 */
`timescale 1ns/1ps
module spimss_slave_link import spimss_pkg::*; (
   input  wire logic                 sck_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 ss_b_i,
   input  wire logic                 mosi_i,
   input  wire logic [SPIMSS_DW-1:0] tx_word_i,
   output logic      [SPIMSS_DW-1:0] rx_word_o,
   output logic                      rx_tgl_o,
   output logic                      miso_o
);

   logic [SPIMSS_BITW-1:0] bit_reg;
   logic [SPIMSS_BITW-1:0] bit_next;
   logic [SPIMSS_DW-1:0]   rx_sh_reg;
   logic [SPIMSS_DW-1:0]   rx_sh_next;
   logic [SPIMSS_DW-1:0]   rx_word_reg;
   logic [SPIMSS_DW-1:0]   rx_word_next;
   logic [SPIMSS_DW-1:0]   tx_sh_reg;
   logic [SPIMSS_DW-1:0]   tx_sh_next;
   logic                   tgl_reg;
   logic                   tgl_next;
   logic                   out_reg;

   // sample on rising edge; only modes with rising sample edge are served
   always_comb begin
      bit_next     = bit_reg + 3'h1;
      rx_sh_next   = {rx_sh_reg[SPIMSS_DW-2:0], mosi_i};
      rx_word_next = rx_word_reg;
      tgl_next     = tgl_reg;
      tx_sh_next   = {tx_sh_reg[SPIMSS_DW-2:0], 1'b0};
      // stale data resent
      // msb already stands on the pin, so the shifter starts one bit on
      if (bit_reg == 3'h0) begin
         tx_sh_next = {tx_word_i[SPIMSS_DW-2:0], 1'b0};
      end
      if (bit_reg == SPIMSS_BIT_LAST) begin
         rx_word_next = rx_sh_next;
         tgl_next     = ~tgl_reg;
      end
   end

   // the frame's own select line clears the count, the link clock may stop
   always_ff @(posedge sck_i or posedge ss_b_i) begin
      if (ss_b_i) begin
         bit_reg <= 3'h0;
      end else begin
         bit_reg <= bit_next;
      end
   end

   always_ff @(posedge sck_i) begin
      rx_sh_reg   <= rx_sh_next;
      rx_word_reg <= rx_word_next;
      tx_sh_reg   <= tx_sh_next;
   end

   // toggle needs a known start before any link edge arrives
   always_ff @(posedge sck_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgl_reg <= 1'b0;
      end else begin
         tgl_reg <= tgl_next;
      end
   end

   // change output on the falling edge, half a period before the sample
   always_ff @(negedge sck_i) begin
      out_reg <= tx_sh_reg[SPIMSS_DW-1];
   end

   assign miso_o    = (bit_reg == 3'h0) ? tx_word_i[SPIMSS_DW-1] : out_reg;
   assign rx_word_o = rx_word_reg;
   assign rx_tgl_o  = tgl_reg;

endmodule // spimss_slave_link

// File: spimss_top.sv
/*
 * spimss_top: master/slave serial controller core with the quirks of the
 * shipped silicon kept on purpose.
 * assumes: control pulses come from logic on CLK_I; SPI_SCK_I is the peer's
 * clock in slave mode and may stop between frames; DMA watches TX_EMPTY_FLAG_O.
 */
`timescale 1ns/1ps
module spimss_top import spimss_pkg::*; (
   input  wire logic                             CLK_I,
   input  wire logic                             RST_B_I,
   input  wire logic                             SPI_SCK_I,
   input  wire logic                             SS_B_I,
   input  wire logic                             MOSI_I,
   input  wire logic                             MISO_I,
   input  wire logic                             ENABLE_I,
   input  wire logic                             DISABLE_I,
   input  wire logic                             SOFT_RESET_I,
   input  wire logic                             MASTER_MODE_I,
   input  wire logic                             MODE_FAULT_DISABLE_I,
   input  wire logic                             CLOCK_POLARITY_SEL_I,
   input  wire logic                             CLOCK_PHASE_SEL_I,
   input  wire logic                             CS_HELD_AFTER_TRANSFER_I,
   input  wire logic [SPIMSS_CSW-1:0]            CS_SELECT_I,
   input  wire logic [SPIMSS_NCS-1:0]            CS_IN_USE_I,
   input  wire logic [SPIMSS_NCS*SPIMSS_DIVW-1:0] SERIAL_CLOCK_DIVISOR_I,
   input  wire logic [SPIMSS_DW-1:0]             TX_DATA_I,
   input  wire logic                             TX_WRITE_I,
   input  wire logic                             RX_READ_I,
   output logic                                  SCK_O,
   output logic                                  SCK_OE_O,
   output logic                                  MOSI_O,
   output logic                                  MOSI_OE_O,
   output logic                                  MISO_O,
   output logic                                  MISO_OE_O,
   output logic      [SPIMSS_NCS-1:0]            CS_B_O,
   output logic                                  TX_EMPTY_FLAG_O,
   output logic                                  RECEIVE_READY_FLAG_O,
   output logic      [SPIMSS_DW-1:0]             RX_DATA_O,
   output logic                                  ENABLED_O,
   output logic                                  MODE_FAULT_O
);

   logic                   ss_s;
   logic                   miso_s;
   logic                   tgl_s;
   logic [SPIMSS_DW-1:0]   link_rx_word;
   logic                   link_rx_tgl;
   logic                   link_miso;
   logic [SPIMSS_DIVW-1:0] div_sel;
   logic [SPIMSS_DIVW-1:0] div_eff;
   logic [SPIMSS_NCS-1:0]  div_is_one;
   logic [SPIMSS_NCS-1:0]  div_not_one;
   logic                   div_mixed;
   logic                   tick;
   logic                   rx_evt;
   logic                   start_ok;

   spimss_state_t          state_reg;
   spimss_state_t          state_next;
   logic                   enabled_reg;
   logic                   enabled_next;
   logic                   modf_reg;
   logic                   modf_next;
   logic [SPIMSS_DW-1:0]   tx_hold_reg;
   logic [SPIMSS_DW-1:0]   tx_hold_next;
   logic                   tx_full_reg;
   logic                   tx_full_next;
   logic [SPIMSS_DW-1:0]   slv_tx_reg;
   logic [SPIMSS_DW-1:0]   slv_tx_next;
   logic [SPIMSS_DW-1:0]   rx_hold_reg;
   logic [SPIMSS_DW-1:0]   rx_hold_next;
   logic                   rx_ready_reg;
   logic                   rx_ready_next;
   logic                   glitch_arm_reg;
   logic                   glitch_arm_next;
   logic                   clock_polarity_sel_last_reg;
   logic                   clock_polarity_sel_last_next;
   logic                   ss_last_reg;
   logic                   ss_last_next;
   logic                   tgl_last_reg;
   logic                   tgl_last_next;
   logic                   sck_reg;
   logic                   sck_next;
   logic [SPIMSS_DW-1:0]   sh_reg;
   logic [SPIMSS_DW-1:0]   sh_next;
   logic [SPIMSS_DW-1:0]   rx_sh_reg;
   logic [SPIMSS_DW-1:0]   rx_sh_next;
   logic [SPIMSS_DIVW-1:0] div_cnt_reg;
   logic [SPIMSS_DIVW-1:0] div_cnt_next;
   logic [SPIMSS_CNTW-1:0] edge_reg;
   logic [SPIMSS_CNTW-1:0] edge_next;
   logic [SPIMSS_NCS-1:0]  cs_b_reg;
   logic [SPIMSS_NCS-1:0]  cs_b_next;
   logic [SPIMSS_CSW-1:0]  last_cs_reg;
   logic [SPIMSS_CSW-1:0]  last_cs_next;

   // pins and the link toggle cross into the core clock
   spimss_sync #(
      .W       (3),
      .RST_VAL (SPIMSS_SYNC_RST)
   ) u_sync (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .d_i     ({SS_B_I, MISO_I, link_rx_tgl}),
      .q_o     ({ss_s, miso_s, tgl_s})
   );

   // slave shifter lives on the peer's clock
   spimss_slave_link u_link (
      .sck_i     (SPI_SCK_I),
      .rst_b_i   (RST_B_I),
      .ss_b_i    (SS_B_I),
      .mosi_i    (MOSI_I),
      .tx_word_i (slv_tx_reg),
      .rx_word_o (link_rx_word),
      .rx_tgl_o  (link_rx_tgl),
      .miso_o    (link_miso)
   );

   // per chip select divisor classification
   genvar gi;
   generate
      for (gi = 0; gi < SPIMSS_NCS; gi++) begin : g_div
         assign div_is_one[gi]  = CS_IN_USE_I[gi] &&
                                  (SERIAL_CLOCK_DIVISOR_I[gi*SPIMSS_DIVW +: SPIMSS_DIVW] == SPIMSS_DIV_ONE);
         assign div_not_one[gi] = CS_IN_USE_I[gi] &&
                                  !div_is_one[gi];
      end
   endgenerate

   // divisor zero acts as one, keeps clock moving
   always_comb begin
      div_sel   = SERIAL_CLOCK_DIVISOR_I[CS_SELECT_I*SPIMSS_DIVW +: SPIMSS_DIVW];
      div_eff   = (div_sel == SPIMSS_DATA_RST) ? SPIMSS_DIV_ONE : div_sel;
      div_mixed = (|div_is_one) && (|div_not_one);
      tick      = (div_cnt_reg == div_eff - SPIMSS_DIV_ONE);
      rx_evt    = tgl_s ^ tgl_last_reg;
      start_ok  = !((CS_SELECT_I == SPIMSS_CS_ZERO) && CS_HELD_AFTER_TRANSFER_I && !MODE_FAULT_DISABLE_I);
   end

   // core next state
   always_comb begin
      state_next      = state_reg;
      enabled_next    = enabled_reg;
      modf_next       = modf_reg;
      tx_hold_next    = tx_hold_reg;
      tx_full_next    = tx_full_reg;
      slv_tx_next     = slv_tx_reg;
      rx_hold_next    = rx_hold_reg;
      rx_ready_next   = rx_ready_reg;
      glitch_arm_next = glitch_arm_reg;
      clock_polarity_sel_last_next  = CLOCK_POLARITY_SEL_I;
      ss_last_next    = ss_s;
      tgl_last_next   = tgl_s;
      sck_next        = sck_reg;
      sh_next         = sh_reg;
      rx_sh_next      = rx_sh_reg;
      div_cnt_next    = div_cnt_reg;
      edge_next       = edge_reg;
      cs_b_next       = cs_b_reg;
      last_cs_next    = last_cs_reg;

      // clearing read comes first so a same-cycle arrival wins
      if (RX_READ_I) begin
         rx_ready_next = 1'b0;
      end

      if (ENABLE_I) begin
         enabled_next = 1'b1;
         if (!MASTER_MODE_I) begin
            rx_ready_next   = 1'b1;
            glitch_arm_next = 1'b1;
         end
      end

      if (DISABLE_I && MASTER_MODE_I) begin
         enabled_next = 1'b0;
         state_next   = SPIMSS_IDLE;
         cs_b_next    = SPIMSS_CS_IDLE;
      end

      // another master pulled our select line low
      if (enabled_reg && MASTER_MODE_I && !MODE_FAULT_DISABLE_I && !ss_s) begin
         modf_next    = 1'b1;
         enabled_next = 1'b0;
         state_next   = SPIMSS_IDLE;
         cs_b_next    = SPIMSS_CS_IDLE;
      end

      if (!MASTER_MODE_I && enabled_reg && (CLOCK_POLARITY_SEL_I != clock_polarity_sel_last_reg)) begin
         glitch_arm_next = 1'b0;
      end

      if (!MASTER_MODE_I && enabled_reg && glitch_arm_reg && ss_last_reg && !ss_s) begin
         rx_ready_next   = 1'b1;
         glitch_arm_next = 1'b0;
      end

      if (!MASTER_MODE_I && enabled_reg && rx_evt) begin
         rx_hold_next  = link_rx_word;
         rx_ready_next = 1'b1;
      end

      if (!MASTER_MODE_I && enabled_reg && ss_s && tx_full_reg) begin
         slv_tx_next  = tx_hold_reg;
         tx_full_next = 1'b0;
      end

      case (state_reg)
         SPIMSS_IDLE: begin
            sck_next     = CLOCK_POLARITY_SEL_I;
            div_cnt_next = SPIMSS_DATA_RST;
            edge_next    = '0;
            if (enabled_reg && MASTER_MODE_I && tx_full_reg && start_ok) begin
               sh_next      = tx_hold_reg;
               tx_full_next = 1'b0;
               cs_b_next    = ~(4'h1 << CS_SELECT_I);
               last_cs_next = CS_SELECT_I;
               if (div_mixed && CLOCK_POLARITY_SEL_I && !CLOCK_PHASE_SEL_I && (CS_SELECT_I != last_cs_reg)) begin
                  state_next = SPIMSS_LEAD;
               end else begin
                  state_next = SPIMSS_SHIFT;
               end
            end
         end
         SPIMSS_LEAD: begin
            div_cnt_next = tick ? SPIMSS_DATA_RST : div_cnt_reg + SPIMSS_DIV_ONE;
            if (tick) begin
               sck_next  = ~sck_reg;
               edge_next = edge_reg + 5'h01;
               if (edge_reg == SPIMSS_LEAD_LAST) begin
                  edge_next  = '0;
                  state_next = SPIMSS_SHIFT;
               end
            end
         end
         SPIMSS_SHIFT: begin
            div_cnt_next = tick ? SPIMSS_DATA_RST : div_cnt_reg + SPIMSS_DIV_ONE;
            if (tick) begin
               sck_next  = ~sck_reg;
               edge_next = edge_reg + 5'h01;
               // even edges lead, odd edges trail
               if (edge_reg[0] == CLOCK_PHASE_SEL_I) begin
                  rx_sh_next = {rx_sh_reg[SPIMSS_DW-2:0], miso_s};
               end else if (edge_reg != '0) begin
                  sh_next = {sh_reg[SPIMSS_DW-2:0], 1'b0};
               end
               if (edge_reg == SPIMSS_EDGE_LAST) begin
                  state_next = SPIMSS_DONE;
               end
            end
         end
         SPIMSS_DONE: begin
            rx_hold_next  = rx_sh_reg;
            rx_ready_next = 1'b1;
            if (!CS_HELD_AFTER_TRANSFER_I) begin
               cs_b_next = SPIMSS_CS_IDLE;
            end
            state_next = SPIMSS_IDLE;
         end
         default: begin
            state_next = SPIMSS_IDLE;
         end
      endcase

      // empty flag left set, words lost
      if (TX_WRITE_I && enabled_reg) begin
         tx_hold_next = TX_DATA_I;
         tx_full_next = 1'b1;
      end

      // soft reset is the only way to stop a slave
      if (SOFT_RESET_I) begin
         state_next      = SPIMSS_IDLE;
         enabled_next    = 1'b0;
         modf_next       = 1'b0;
         tx_full_next    = 1'b0;
         rx_ready_next   = 1'b0;
         glitch_arm_next = 1'b0;
         cs_b_next       = SPIMSS_CS_IDLE;
      end
   end

   // core registers
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         state_reg      <= SPIMSS_IDLE;
         enabled_reg    <= 1'b0;
         modf_reg       <= 1'b0;
         tx_hold_reg    <= SPIMSS_DATA_RST;
         tx_full_reg    <= 1'b0;
         slv_tx_reg     <= SPIMSS_DATA_RST;
         rx_hold_reg    <= SPIMSS_DATA_RST;
         rx_ready_reg   <= 1'b0;
         glitch_arm_reg <= 1'b0;
         clock_polarity_sel_last_reg  <= 1'b0;
         ss_last_reg    <= 1'b1;
         tgl_last_reg   <= 1'b0;
         sck_reg        <= 1'b0;
         sh_reg         <= SPIMSS_DATA_RST;
         rx_sh_reg      <= SPIMSS_DATA_RST;
         div_cnt_reg    <= SPIMSS_DATA_RST;
         edge_reg       <= '0;
         cs_b_reg       <= SPIMSS_CS_IDLE;
         last_cs_reg    <= SPIMSS_CS_ZERO;
      end else begin
         state_reg      <= state_next;
         enabled_reg    <= enabled_next;
         modf_reg       <= modf_next;
         tx_hold_reg    <= tx_hold_next;
         tx_full_reg    <= tx_full_next;
         slv_tx_reg     <= slv_tx_next;
         rx_hold_reg    <= rx_hold_next;
         rx_ready_reg   <= rx_ready_next;
         glitch_arm_reg <= glitch_arm_next;
         clock_polarity_sel_last_reg  <= clock_polarity_sel_last_next;
         ss_last_reg    <= ss_last_next;
         tgl_last_reg   <= tgl_last_next;
         sck_reg        <= sck_next;
         sh_reg         <= sh_next;
         rx_sh_reg      <= rx_sh_next;
         div_cnt_reg    <= div_cnt_next;
         edge_reg       <= edge_next;
         cs_b_reg       <= cs_b_next;
         last_cs_reg    <= last_cs_next;
      end
   end

   // pin drivers; slave drives only while selected
   assign SCK_O                = sck_reg;
   assign SCK_OE_O             = enabled_reg && MASTER_MODE_I;
   assign MOSI_O               = sh_reg[SPIMSS_DW-1];
   assign MOSI_OE_O            = enabled_reg && MASTER_MODE_I;
   assign MISO_O               = link_miso;
   assign MISO_OE_O            = enabled_reg && !MASTER_MODE_I && !SS_B_I;
   assign CS_B_O               = cs_b_reg;
   // flag is the inverse of holding full
   assign TX_EMPTY_FLAG_O      = !tx_full_reg;
   assign RECEIVE_READY_FLAG_O = rx_ready_reg;
   assign RX_DATA_O            = rx_hold_reg;
   assign ENABLED_O            = enabled_reg;
   assign MODE_FAULT_O         = modf_reg;

endmodule // spimss_top

// File: spimss_checker.sv
/* spimss_checker: port-level assertions on spimss_top.
   assumes: CLK_I, synchronous active-low RST_B_I. */
`timescale 1ns/1ps
module spimss_checker import spimss_pkg::*; (
   input wire logic                  CLK_I,
   input wire logic                  RST_B_I,
   input wire logic                  ENABLE_I,
   input wire logic                  DISABLE_I,
   input wire logic                  SOFT_RESET_I,
   input wire logic                  TX_WRITE_I,
   input wire logic                  RX_READ_I,
   input wire logic                  MASTER_MODE_I,
   input wire logic                  MODE_FAULT_DISABLE_I,
   input wire logic                  CS_HELD_AFTER_TRANSFER_I,
   input wire logic [SPIMSS_CSW-1:0] CS_SELECT_I,
   input wire logic [SPIMSS_NCS-1:0] CS_B_O,
   input wire logic                  TX_EMPTY_FLAG_O,
   input wire logic                  RECEIVE_READY_FLAG_O,
   input wire logic                  ENABLED_O,
   input wire logic                  MODE_FAULT_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // soft reset outranks the commands judged below; read is kept out as well
   logic calm;
   assign calm = !SOFT_RESET_I && !RX_READ_I;
   a_slave_no_fault: assert property (!MASTER_MODE_I && !MODE_FAULT_O |=> !MODE_FAULT_O)
      else $error("slave fault");
   a_slave_stray_ready: assert property (!ENABLED_O && ENABLE_I && !MASTER_MODE_I && calm
      |=> ENABLED_O && RECEIVE_READY_FLAG_O)
      else $error("no stray ready");
   a_slave_keeps_on: assert property (ENABLED_O && !MASTER_MODE_I && DISABLE_I && calm |=> ENABLED_O)
      else $error("slave disabled");
   a_soft_reset_stop: assert property (SOFT_RESET_I
      |=> !ENABLED_O && !RECEIVE_READY_FLAG_O && TX_EMPTY_FLAG_O && CS_B_O == SPIMSS_CS_IDLE)
      else $error("reset ignored");
   a_held_zero_hang: assert property (ENABLED_O && MASTER_MODE_I && CS_SELECT_I == SPIMSS_CS_ZERO
      && CS_HELD_AFTER_TRANSFER_I && !MODE_FAULT_DISABLE_I && CS_B_O == SPIMSS_CS_IDLE
      |=> CS_B_O == SPIMSS_CS_IDLE)
      else $error("held start");
   a_drop_disabled: assert property (!ENABLED_O && TX_WRITE_I && !SOFT_RESET_I |=> $stable(TX_EMPTY_FLAG_O))
      else $error("flag moved");
   a_disable_flag: assert property (DISABLE_I && TX_EMPTY_FLAG_O && !TX_WRITE_I |=> TX_EMPTY_FLAG_O)
      else $error("flag cleared");
   a_write_clears: assert property (ENABLED_O && TX_WRITE_I && !SOFT_RESET_I |=> !TX_EMPTY_FLAG_O)
      else $error("flag kept");
   c_slave_ready: cover property (ENABLED_O && !MASTER_MODE_I && RECEIVE_READY_FLAG_O);
   c_drop_write: cover property (TX_WRITE_I && !ENABLED_O);
   c_second_select: cover property ($fell(CS_B_O[1]));
endmodule // spimss_checker

bind spimss_top spimss_checker spimss_checker_inst (.*);

// File: spimss_peer.sv
/* spimss_peer: far-side serial peer, a frame-driving master for slave tests
   and a loopback slave otherwise.
   assumes: the bench starts frames; link clock 15 ns, still between frames. */
`timescale 1ns/1ps
module spimss_peer import spimss_pkg::*; (
   input  wire logic [SPIMSS_NCS-1:0] cs_b_i,
   input  wire logic                  mosi_i,
   input  wire logic                  miso_i,
   output logic                       sck_o,
   output logic                       ss_b_o,
   output logic                       mosi_o,
   output logic                       miso_o
);
   logic last_q = 1'b0;
   initial {sck_o, ss_b_o, mosi_o} = 3'b010;
   // loopback; deselected shows the inverse
   always @(mosi_i) if (cs_b_i != SPIMSS_CS_IDLE) last_q = mosi_i;
   always @(*) miso_o = (cs_b_i != SPIMSS_CS_IDLE) ? mosi_i : ~last_q;
   // one byte msb first, sampling the slave on rising edges
   task automatic frame(input logic [SPIMSS_DW-1:0] tx, output logic [SPIMSS_DW-1:0] rx);
      ss_b_o = 1'b0;
      #40;
      for (int i = SPIMSS_DW-1; i >= 0; i--) begin
         mosi_o = tx[i];
         #7.5 sck_o = 1'b1;
         rx[i] = miso_i;
         #7.5 sck_o = 1'b0;
      end
      #40 ss_b_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask
endmodule // spimss_peer

// File: test_spimss_top.sv
/* test_spimss_top: self-checking bench for spimss_top with a serial peer.
   assumes: package, checker and peer compiled first. */
`timescale 1ns/1ps
module test_spimss_top import spimss_pkg::*;;
   localparam logic [4:0] EN = 5'h10, DIS = 5'h08, SRST = 5'h04, WR = 5'h02, RD = 5'h01;
   logic CLK_I = 1'b0, RST_B_I = 1'b0, ENABLE_I = 1'b0, DISABLE_I = 1'b0, SOFT_RESET_I = 1'b0;
   logic TX_WRITE_I = 1'b0, RX_READ_I = 1'b0, MASTER_MODE_I = 1'b0, MODE_FAULT_DISABLE_I = 1'b1;
   logic CLOCK_POLARITY_SEL_I = 1'b0, CLOCK_PHASE_SEL_I = 1'b0, CS_HELD_AFTER_TRANSFER_I = 1'b0;
   logic [SPIMSS_CSW-1:0]             CS_SELECT_I = 2'h0;
   logic [SPIMSS_NCS-1:0]             CS_IN_USE_I = 4'h1, CS_B_O;
   logic [SPIMSS_NCS*SPIMSS_DIVW-1:0] SERIAL_CLOCK_DIVISOR_I = 32'h04040404;
   logic [SPIMSS_DW-1:0]              TX_DATA_I = 8'h00, RX_DATA_O;
   logic SPI_SCK_I, SS_B_I, MOSI_I, MISO_I, SCK_O, SCK_OE_O, MOSI_O, MOSI_OE_O, MISO_O, MISO_OE_O;
   logic TX_EMPTY_FLAG_O, RECEIVE_READY_FLAG_O, ENABLED_O, MODE_FAULT_O, sck_q = 1'b0;
   int   fail_count = 0, num_checks = 0, falls = 0;
   spimss_top spimss_top_inst (.*);
   spimss_peer spimss_peer_inst (.cs_b_i(CS_B_O), .mosi_i(MOSI_O), .miso_i(MISO_O), .sck_o(SPI_SCK_I),
      .ss_b_o(SS_B_I), .mosi_o(MOSI_I), .miso_o(MISO_I));
   initial forever #12.5 CLK_I = ~CLK_I;
   // falling serial clock edges while a select is low
   always @(posedge CLK_I) begin
      sck_q <= SCK_O;
      if (CS_B_O !== SPIMSS_CS_IDLE && sck_q === 1'b1 && SCK_O === 1'b0) falls <= falls + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one-cycle pulse, answer read after the taking edge
   task automatic cmd(input logic [4:0] p, input logic [7:0] d);
      @(posedge CLK_I);
      {ENABLE_I, DISABLE_I, SOFT_RESET_I, TX_WRITE_I, RX_READ_I} <= p;
      TX_DATA_I <= d;
      @(posedge CLK_I);
      {ENABLE_I, DISABLE_I, SOFT_RESET_I, TX_WRITE_I, RX_READ_I} <= 5'h00;
      #1;
   endtask
   task automatic setup(input logic m, mfd, held, clock_polarity_sel, clock_phase_sel, input logic [3:0] use_, input logic [31:0] dv);
      cmd(SRST, 8'h00);
      @(posedge CLK_I);
      {MASTER_MODE_I, MODE_FAULT_DISABLE_I, CS_HELD_AFTER_TRANSFER_I} <= {m, mfd, held};
      {CLOCK_POLARITY_SEL_I, CLOCK_PHASE_SEL_I, CS_IN_USE_I, SERIAL_CLOCK_DIVISOR_I} <= {clock_polarity_sel, clock_phase_sel, use_, dv};
      cmd(EN, 8'h00);
      chk(ENABLED_O, 1'b1, "en");
      chk({SCK_OE_O, MOSI_OE_O, MISO_OE_O}, {m, m, 1'b0}, "oe");
   endtask
   // master byte via loopback; fexp ff skips count
   task automatic xfer(input logic [1:0] cs, input logic [7:0] d, input logic [7:0] fexp);
      int f0;
      @(posedge CLK_I);
      CS_SELECT_I <= cs;
      f0 = falls;
      cmd(WR, d);
      chk(TX_EMPTY_FLAG_O, 1'b0, "empty");
      for (int n = 0; n < 50 && CS_B_O === SPIMSS_CS_IDLE; n++) @(posedge CLK_I);
      for (int n = 0; n < 400 && CS_B_O !== SPIMSS_CS_IDLE; n++) @(posedge CLK_I);
      repeat (2) @(posedge CLK_I);
      #1;
      if (fexp != 8'hff) chk(8'(falls - f0), fexp, "falls");
      if (!CLOCK_POLARITY_SEL_I && !CLOCK_PHASE_SEL_I) chk(RX_DATA_O, d, "loop");
      chk(RECEIVE_READY_FLAG_O, 1'b1, "ready");
   endtask
   task automatic test_pulse();
      logic [31:0] divs [3] = '{32'h04040201, 32'h04040101, 32'h04040201};
      logic [7:0]  exp  [3] = '{8'h09, 8'h08, 8'h08};
      for (int i = 0; i < 3; i++) begin
         // second case keeps both in-use divisors at one
         setup(1'b1, 1'b1, 1'b0, 1'b1, i == 2, 4'h3, divs[i]);
         xfer(2'h0, 8'h5a, 8'hff);
         xfer(2'h0, 8'h5a, 8'h08);
         xfer(2'h1, 8'ha5, exp[i]);
      end
      setup(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 32'h04040404);
      xfer(2'h0, 8'h96, 8'h08);
      xfer(2'h0, 8'h3c, 8'h08);
      $display("test master clock done");
   endtask
   task automatic test_held();
      setup(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 32'h04040404);
      cmd(WR, 8'h11);
      repeat (40) @(posedge CLK_I);
      #1;
      chk(CS_B_O, SPIMSS_CS_IDLE, "cs idle");
      chk(TX_EMPTY_FLAG_O, 1'b0, "pending");
      @(posedge CLK_I);
      MODE_FAULT_DISABLE_I <= 1'b1;
      for (int n = 0; n < 20 && CS_B_O === SPIMSS_CS_IDLE; n++) @(posedge CLK_I);
      #1;
      chk(CS_B_O[0], 1'b0, "cs0");
      chk(MODE_FAULT_O, 1'b0, "modf");
      repeat (60) @(posedge CLK_I);
      $display("test held select done");
   endtask
   task automatic test_dma();
      setup(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 32'h04040404);
      // channel feeds on empty flag, not stopped first
      for (int k = 0; k < 5; k++) begin
         for (int n = 0; n < 100 && TX_EMPTY_FLAG_O !== 1'b1; n++) @(posedge CLK_I);
         if (k == 2) cmd(DIS, 8'h00);
         cmd(WR, 8'(k));
         if (k >= 2) chk(TX_EMPTY_FLAG_O, 1'b1, "drop");
      end
      chk(ENABLED_O, 1'b0, "dis");
      cmd(EN, 8'h00);
      xfer(2'h0, 8'h77, 8'h08);
      $display("test dma disable done");
   endtask
   task automatic test_slave();
      logic [7:0] rx;
      setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 32'h04040404);
      chk(RECEIVE_READY_FLAG_O, 1'b1, "stray");
      @(posedge CLK_I);
      CLOCK_POLARITY_SEL_I <= 1'b1;
      @(posedge CLK_I);
      CLOCK_POLARITY_SEL_I <= 1'b0;
      cmd(RD, 8'h00);
      chk(RECEIVE_READY_FLAG_O, 1'b0, "flip");
      cmd(WR, 8'ha5);
      repeat (5) @(posedge CLK_I);
      for (int f = 0; f < 2; f++) begin
         spimss_peer_inst.frame(8'h3c ^ 8'(f), rx);
         for (int n = 0; n < 20 && RECEIVE_READY_FLAG_O !== 1'b1; n++) @(posedge CLK_I);
         #1;
         chk(RX_DATA_O, 8'h3c ^ 8'(f), "rx");
         chk(rx, 8'ha5, "tx");
         chk(MODE_FAULT_O, 1'b0, "modf");
         cmd(RD, 8'h00);
      end
      cmd(DIS, 8'h00);
      chk(ENABLED_O, 1'b1, "dis");
      cmd(SRST, 8'h00);
      chk(ENABLED_O, 1'b0, "srst");
      $display("test slave done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // the whole run is under a thousand cycles
   initial begin
      #1000000;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      repeat (20) @(posedge CLK_I);
      RST_B_I <= 1'b1;
      test_pulse();
      test_held();
      test_dma();
      test_slave();
      stop_test();
   end
endmodule // test_spimss_top
